// ### rtl/icw_map.svh
// Contract
// - Word 85 reports bit 14 one for no-operation support; bit 15 obsolete, zero.
// - Word 86 bits 0, 1 and 4 always read zero.
// - Word 86 bit 3 set only while power management enabled; bit 2 shows card set.
// - At most one DMA mode selected; Ultra and Multiword selections exclude each other.
// - Word 88 bits 13..8 one-hot selected Ultra DMA mode; bits 15-14 reserved.
// - Word 88 bits 5..0 show Ultra support; each supported mode implies all lower.
// - Erase time words: 0 unspecified, 1-254 twice minutes, 255 above 508 minutes.
// - Word 91 low byte returns the current power management level.
// - Word 128 bit 8 one means maximum level, zero with security enabled means high.
// - Word 128 bit 5 set when enhanced security erase is supported.
// - Expired attempt count sets bit 4; unlock and erase abort until reset.
// - Word 128 bits 3..0: frozen, locked, enabled, security supported.
// - Word 160 bit 15 set only for a valid description; bit 14 reads zero.
// - Word 160 bit 13 no level-one commands, bit 12 those commands disabled.
// - Word 160 bits 11..0 carry maximum current in milliamperes.
// - Word 162 bit 0 content protection scheme support; bits 15..1 reserved.
// - Word 163 bits 2-0 highest advanced PIO mode: 0 word 64, 1 mode 5, 2 mode 6.
// - Word 163 bits 5-3 highest advanced Multiword mode: 0 word 63, 1 mode 3, 2 mode 4.
// - Word 163 bits 8-6 selected advanced PIO mode, same codes.
// - Word 163 bits 11-9 selected advanced Multiword mode; bits 15-12 reserved.
// - Word 164 bits 2-0 fastest I/O cycle: 255, 120, 100, 80 ns.
// - Word 164 bits 5-3 fastest memory cycle: 250, 120, 100, 80 ns; rest reserved.
// - Words are returned as part of the identify device parameter data.
`ifndef ICW_MAP_SVH
`define ICW_MAP_SVH

`define ICW_W_FEAT_A 8'h55
`define ICW_W_FEAT_B 8'h56
`define ICW_W_UDMA 8'h58
`define ICW_W_ERASE 8'h59
`define ICW_W_ENH_ERASE 8'h5a
`define ICW_W_APM_LEVEL 8'h5b
`define ICW_W_SEC_STATUS 8'h80
`define ICW_W_POWER_REQ 8'ha0
`define ICW_W_KEY_SCHEME 8'ha2
`define ICW_W_IDE_TIMING 8'ha3
`define ICW_W_CARD_TIMING 8'ha4

`define ICW_B85_NOP 14
`define ICW_B86_CARD_SET 2
`define ICW_B86_APM_ON 3
`define ICW_B128_LEVEL_MAX 8
`define ICW_B128_ENH_ERASE 5
`define ICW_B128_EXPIRED 4
`define ICW_B128_FROZEN 3
`define ICW_B128_LOCKED 2
`define ICW_B128_ENABLED 1
`define ICW_B128_SUPPORTED 0

`define ICW_SF_XFER_MODE 8'h03
`define ICW_SF_APM_ON 8'h05
`define ICW_SF_APM_OFF 8'h85
`define ICW_XM_PIO 5'h01
`define ICW_XM_MWDMA 5'h04
`define ICW_XM_UDMA 5'h08

`define ICW_ERASE_CODE_MAX 8'hff
`define ICW_ERASE_LIMIT_MIN 508
`define ICW_UNLOCK_TRIES 3'h5
`define ICW_WORD_RESET 16'h0000

`endif

// ### rtl/icw_pkg.sv
package icw_pkg;

	typedef struct packed
	{
		logic rd;
		logic [7:0] word;
	} icw_id_req_t;

	typedef struct packed
	{
		logic valid;
		logic [7:0] sub;
		logic [7:0] count;
	} icw_feat_t;

	typedef enum logic [2:0]
	{
		ICW_SOP_SET_PW = 3'b000,
		ICW_SOP_UNLOCK = 3'b001,
		ICW_SOP_ERASE = 3'b010,
		ICW_SOP_FREEZE = 3'b011,
		ICW_SOP_DISABLE = 3'b100
	} icw_sec_op_t;

	typedef struct packed
	{
		logic valid;
		icw_sec_op_t op;
		logic pw_ok;
		logic level_max;
	} icw_sec_cmd_t;

	typedef enum logic [1:0]
	{
		ICW_SEC_OFF = 2'b00,
		ICW_SEC_OPEN = 2'b01,
		ICW_SEC_LOCKED = 2'b10
	} icw_sec_st_t;

endpackage

// ### rtl/icw_identify_words.sv
`timescale 1ns/1ps
`include "icw_map.svh"
module icw_identify_words #(
	parameter int UDMA_MAX = 5,
	parameter logic [2:0] ADV_PIO_SUP = 3'h2,
	parameter logic [2:0] ADV_MW_SUP = 3'h2,
	parameter logic [2:0] IO_CYCLE = 3'h3,
	parameter logic [2:0] MEM_CYCLE = 3'h3,
	parameter int ERASE_MIN = 0,
	parameter int ENH_ERASE_MIN = 0,
	parameter logic [11:0] MAX_CURRENT_MA = 12'h064,
	parameter bit PWR_DESC_VALID = 1'b1,
	parameter bit NO_LEVEL1_CMDS = 1'b0,
	parameter bit CARD_SET = 1'b1,
	parameter bit SEC_SUPPORTED = 1'b1,
	parameter bit ENH_ERASE_SUPPORTED = 1'b0,
	parameter bit KEY_SCHEME_SUPPORTED = 1'b0,
	parameter logic [2:0] UNLOCK_TRIES = `ICW_UNLOCK_TRIES
)(
	input wire logic ref_clk,
	input wire logic rst,
	input wire icw_pkg::icw_id_req_t id_req,
	input wire icw_pkg::icw_feat_t feat,
	input wire icw_pkg::icw_sec_cmd_t sec_cmd,
	input wire logic pw_stored,
	input wire logic pw_level_max,
	input wire logic level1_power_cmds_disabled,
	output logic [15:0] id_data,
	output logic id_valid,
	output logic id_hit,
	output logic feat_abort,
	output logic sec_abort
);

	function automatic logic [7:0] erase_code(input int minutes);
		logic [7:0] code;
		code = 8'h00;
		if (minutes > `ICW_ERASE_LIMIT_MIN)
		begin
			code = `ICW_ERASE_CODE_MAX;
		end
		else if (minutes > 0)
		begin
			code = 8'((minutes + 1) / 2);
		end
		return code;
	endfunction

	localparam logic [7:0] ERASE_CODE = erase_code(ERASE_MIN);
	localparam logic [7:0] ENH_ERASE_CODE = erase_code(ENH_ERASE_MIN);
	localparam logic [3:0] PIO_TOP = (ADV_PIO_SUP == 3'h0) ? 4'h4 : 4'(4'h4 + ADV_PIO_SUP);
	localparam logic [3:0] MW_TOP = (ADV_MW_SUP == 3'h0) ? 4'h2 : 4'(4'h2 + ADV_MW_SUP);

	icw_pkg::icw_sec_st_t sec_st;
	logic sec_level_max;
	logic frozen;
	logic expired;
	logic [2:0] tries_left;
	logic por_done;
	logic apm_on;
	logic [7:0] apm_level;
	logic [5:0] udma_sel;
	logic mw_on;
	logic [2:0] mw_mode;
	logic [2:0] pio_mode;
	logic [5:0] udma_sup;
	logic [2:0] pio_adv_sel;
	logic [2:0] mw_adv_sel;
	logic xfer_ok;
	logic feat_ok;
	logic [15:0] next_data;
	logic next_hit;

	// Cumulative support mask: mode n reported only with all lower modes
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++)
		begin : g_udma_sup
			assign udma_sup[gi] = (gi <= UDMA_MAX);
		end
	endgenerate

	// Transfer mode requests are checked against the advertised maxima
	always_comb
	begin
		xfer_ok = 1'b0;
		case (feat.count[7:3])
			`ICW_XM_UDMA:
				xfer_ok = (UDMA_MAX >= 0) && (int'(feat.count[2:0]) <= UDMA_MAX);
			`ICW_XM_MWDMA:
				xfer_ok = ({1'b0, feat.count[2:0]} <= MW_TOP);
			`ICW_XM_PIO, 5'h00:
				xfer_ok = ({1'b0, feat.count[2:0]} <= PIO_TOP);
			default:
				xfer_ok = 1'b0;
		endcase
	end

	always_comb
	begin
		case (feat.sub)
			`ICW_SF_XFER_MODE:
				feat_ok = xfer_ok;
			`ICW_SF_APM_ON:
				feat_ok = (feat.count != 8'h00);
			`ICW_SF_APM_OFF:
				feat_ok = 1'b1;
			// Unknown subcommands are ignored, not aborted
			default:
				feat_ok = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			feat_abort <= 1'b0;
		end
		else
		begin
			feat_abort <= feat.valid && !feat_ok;
		end
	end

	// Power management level follows set-features enable and disable
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			apm_on <= 1'b0;
			apm_level <= 8'h00;
		end
		else if (feat.valid && feat_ok)
		begin
			if (feat.sub == `ICW_SF_APM_ON)
			begin
				apm_on <= 1'b1;
				apm_level <= feat.count;
			end
			else if (feat.sub == `ICW_SF_APM_OFF)
			begin
				apm_on <= 1'b0;
				apm_level <= 8'h00;
			end
		end
	end

	// Transfer mode selection; a DMA pick of one kind clears the other kind
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			udma_sel <= 6'h00;
			mw_on <= 1'b0;
			mw_mode <= 3'h0;
			pio_mode <= 3'h0;
		end
		else if (feat.valid && feat_ok && feat.sub == `ICW_SF_XFER_MODE)
		begin
			case (feat.count[7:3])
				`ICW_XM_UDMA:
				begin
					udma_sel <= 6'(6'h01 << feat.count[2:0]);
					mw_on <= 1'b0;
				end
				`ICW_XM_MWDMA:
				begin
					mw_on <= 1'b1;
					mw_mode <= feat.count[2:0];
					udma_sel <= 6'h00;
				end
				default:
				begin
					pio_mode <= feat.count[2:0];
				end
			endcase
		end
	end

	// Advanced codes: 0 means the legacy word covers the selected mode
	always_comb
	begin
		pio_adv_sel = 3'h0;
		mw_adv_sel = 3'h0;
		if (pio_mode >= 3'h5)
		begin
			pio_adv_sel = 3'(pio_mode - 3'h4);
		end
		if (mw_on && mw_mode >= 3'h3)
		begin
			mw_adv_sel = 3'(mw_mode - 3'h2);
		end
	end

	// Security state; a stored password locks the card once reset releases
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			sec_st <= icw_pkg::ICW_SEC_OFF;
			sec_level_max <= 1'b0;
			frozen <= 1'b0;
			expired <= 1'b0;
			tries_left <= UNLOCK_TRIES;
			por_done <= 1'b0;
			sec_abort <= 1'b0;
		end
		else
		begin
			por_done <= 1'b1;
			sec_abort <= 1'b0;
			if (!por_done)
			begin
				if (SEC_SUPPORTED && pw_stored)
				begin
					sec_st <= icw_pkg::ICW_SEC_LOCKED;
					sec_level_max <= pw_level_max;
				end
			end
			else if (sec_cmd.valid)
			begin
				if (!SEC_SUPPORTED)
				begin
					sec_abort <= 1'b1;
				end
				else
				begin
					case (sec_cmd.op)
						icw_pkg::ICW_SOP_SET_PW:
						begin
							if (frozen || sec_st == icw_pkg::ICW_SEC_LOCKED)
							begin
								sec_abort <= 1'b1;
							end
							else
							begin
								sec_st <= icw_pkg::ICW_SEC_OPEN;
								sec_level_max <= sec_cmd.level_max;
							end
						end
						icw_pkg::ICW_SOP_UNLOCK, icw_pkg::ICW_SOP_ERASE:
						begin
							if (expired)
							begin
								sec_abort <= 1'b1;
							end
							else if (!sec_cmd.pw_ok || (frozen && sec_cmd.op == icw_pkg::ICW_SOP_ERASE))
							begin
								sec_abort <= 1'b1;
								// Each bad password uses one try; the last one expires the count
								if (!sec_cmd.pw_ok)
								begin
									tries_left <= 3'(tries_left - 3'h1);
									if (tries_left <= 3'h1)
									begin
										expired <= 1'b1;
									end
								end
							end
							else if (sec_cmd.op == icw_pkg::ICW_SOP_ERASE)
							begin
								sec_st <= icw_pkg::ICW_SEC_OFF;
								sec_level_max <= 1'b0;
							end
							else if (sec_st == icw_pkg::ICW_SEC_LOCKED)
							begin
								sec_st <= icw_pkg::ICW_SEC_OPEN;
							end
						end
						icw_pkg::ICW_SOP_FREEZE:
						begin
							if (sec_st == icw_pkg::ICW_SEC_LOCKED)
							begin
								sec_abort <= 1'b1;
							end
							else
							begin
								frozen <= 1'b1;
							end
						end
						icw_pkg::ICW_SOP_DISABLE:
						begin
							if (sec_st != icw_pkg::ICW_SEC_OPEN || frozen || !sec_cmd.pw_ok)
							begin
								sec_abort <= 1'b1;
							end
							else
							begin
								sec_st <= icw_pkg::ICW_SEC_OFF;
								sec_level_max <= 1'b0;
							end
						end
						default:
						begin
							sec_abort <= 1'b1;
						end
					endcase
				end
			end
		end
	end

	// Word assembly; unlisted and reserved bits stay zero
	always_comb
	begin
		next_data = `ICW_WORD_RESET;
		next_hit = 1'b1;
		case (id_req.word)
			`ICW_W_FEAT_A:
				next_data[`ICW_B85_NOP] = 1'b1;
			`ICW_W_FEAT_B:
			begin
				next_data[`ICW_B86_CARD_SET] = CARD_SET;
				next_data[`ICW_B86_APM_ON] = apm_on;
			end
			`ICW_W_UDMA:
				next_data = {2'b00, udma_sel, 2'b00, udma_sup};
			`ICW_W_ERASE:
				next_data = {8'h00, ERASE_CODE};
			`ICW_W_ENH_ERASE:
				next_data = {8'h00, ENH_ERASE_CODE};
			`ICW_W_APM_LEVEL:
				next_data = {8'h00, apm_level};
			`ICW_W_SEC_STATUS:
			begin
				next_data[`ICW_B128_LEVEL_MAX] = sec_level_max && sec_st != icw_pkg::ICW_SEC_OFF;
				next_data[`ICW_B128_ENH_ERASE] = ENH_ERASE_SUPPORTED;
				next_data[`ICW_B128_EXPIRED] = expired;
				next_data[`ICW_B128_FROZEN] = frozen;
				next_data[`ICW_B128_LOCKED] = sec_st == icw_pkg::ICW_SEC_LOCKED;
				next_data[`ICW_B128_ENABLED] = sec_st != icw_pkg::ICW_SEC_OFF;
				next_data[`ICW_B128_SUPPORTED] = SEC_SUPPORTED;
			end
			`ICW_W_POWER_REQ:
				next_data = {PWR_DESC_VALID, 1'b0, NO_LEVEL1_CMDS,
					level1_power_cmds_disabled, MAX_CURRENT_MA};
			`ICW_W_KEY_SCHEME:
				next_data = {15'h0000, KEY_SCHEME_SUPPORTED};
			`ICW_W_IDE_TIMING:
				next_data = {4'h0, mw_adv_sel, pio_adv_sel, ADV_MW_SUP, ADV_PIO_SUP};
			`ICW_W_CARD_TIMING:
				next_data = {10'h000, MEM_CYCLE, IO_CYCLE};
			default:
				next_hit = 1'b0;
		endcase
	end

	// Identify readout, one word per request, answered on the next edge
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			id_data <= `ICW_WORD_RESET;
			id_valid <= 1'b0;
			id_hit <= 1'b0;
		end
		else
		begin
			id_valid <= id_req.rd;
			// Data and hit hold between reads
			if (id_req.rd)
			begin
				id_data <= next_data;
				id_hit <= next_hit;
			end
		end
	end

endmodule

// ### rtl/icw_unused_placeholder_none.sv
`timescale 1ns/1ps

// ### verif/icw_identify_words_asserts.sv
`timescale 1ns/1ps
module icw_identify_words_asserts (
	input wire logic ref_clk,
	input wire logic rst,
	input wire icw_pkg::icw_id_req_t id_req,
	input wire logic level1_power_cmds_disabled,
	input wire logic [15:0] id_data,
	input wire logic id_valid,
	input wire logic id_hit,
	input wire logic feat_abort,
	input wire logic sec_abort
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (rst);
	logic [7:0] w;
	always_ff @(posedge ref_clk)
		w <= id_req.word;
	a_read_answer: assert property (id_req.rd |=> id_valid)
		else $error("read not answered");
	a_miss_zero: assert property (id_valid && !id_hit |-> id_data == 16'h0000)
		else $error("unmapped word not zero");
	a_nop_word: assert property (id_valid && w == 8'h55 |-> id_data == 16'h4000)
		else $error("word 85 wrong");
	a_feat_bits: assert property (id_valid && w == 8'h56 |-> id_data[15:4] == 12'h000 && !id_data[1:0])
		else $error("word 86 bits wrong");
	a_udma_sel: assert property (id_valid && w == 8'h58 |-> $onehot0(id_data[13:8]) && !id_data[15:14])
		else $error("selected mode not one-hot");
	a_udma_sup: assert property (id_valid && w == 8'h58 |-> ((id_data[5:0] + 6'h01) & id_data[5:0]) == 6'h00)
		else $error("support bits have a gap");
	a_power_word: assert property (id_valid && w == 8'ha0 |->
		!id_data[14] && id_data[12] == $past(level1_power_cmds_disabled))
		else $error("word 160 flags wrong");
	a_ide_codes: assert property (id_valid && w == 8'ha3 |->
		id_data[15:12] == 4'h0 && id_data[2:0] < 3'h3
		&& id_data[5:3] < 3'h3 && id_data[8:6] < 3'h3 && id_data[11:9] < 3'h3)
		else $error("word 163 code reserved");
	a_key_word: assert property (id_valid && w == 8'ha2 |-> id_data[15:1] == 15'h0000)
		else $error("word 162 reserved bits set");
	a_card_codes: assert property (id_valid && w == 8'ha4 |->
		id_data[15:6] == 10'h000 && id_data[2:0] < 3'h4 && id_data[5:3] < 3'h4)
		else $error("word 164 code reserved");
	a_byte_words: assert property (id_valid && (w == 8'h59 || w == 8'h5a || w == 8'h5b) |->
		id_data[15:8] == 8'h00)
		else $error("byte word upper half set");
	c_locked: cover property (id_valid && w == 8'h80 && id_data[2]);
	c_feat_abort: cover property (feat_abort);
	c_sec_abort: cover property (sec_abort);
	c_miss: cover property (id_valid && !id_hit);
endmodule

bind icw_identify_words icw_identify_words_asserts u_asserts (
	.ref_clk(ref_clk),
	.rst(rst),
	.id_req(id_req),
	.level1_power_cmds_disabled(level1_power_cmds_disabled),
	.id_data(id_data),
	.id_valid(id_valid),
	.id_hit(id_hit),
	.feat_abort(feat_abort),
	.sec_abort(sec_abort)
);

// ### verif/icw_host_model.sv
`timescale 1ns/1ps
module icw_host_model (
	input wire logic ref_clk,
	output icw_pkg::icw_id_req_t id_req,
	output icw_pkg::icw_feat_t feat,
	output icw_pkg::icw_sec_cmd_t sec_cmd,
	input wire logic [15:0] id_data,
	input wire logic id_valid,
	input wire logic id_hit,
	input wire logic feat_abort,
	input wire logic sec_abort
);
	initial
	begin
		id_req = '0;
		feat = '0;
		sec_cmd = '0;
	end
	// On release rd and valid drop to zero; payload except the security op is inverted
	task automatic read_word(input logic [7:0] a, output logic [15:0] d, output logic v, output logic h);
		@(posedge ref_clk);
		#1 id_req = '{1'b1, a};
		@(posedge ref_clk);
		#1 id_req = '{1'b0, ~a};
		d = id_data;
		v = id_valid;
		h = id_hit;
	endtask
	task automatic set_feat(input logic [7:0] s, input logic [7:0] c, output logic ab);
		@(posedge ref_clk);
		#1 feat = '{1'b1, s, c};
		@(posedge ref_clk);
		#1 feat = '{1'b0, ~s, ~c};
		ab = feat_abort;
	endtask
	task automatic sec(input icw_pkg::icw_sec_op_t op, input logic ok, input logic lm, output logic ab);
		@(posedge ref_clk);
		#1 sec_cmd = '{1'b1, op, ok, lm};
		@(posedge ref_clk);
		#1 sec_cmd = '{1'b0, op, ~ok, ~lm};
		ab = sec_abort;
	endtask
endmodule

// ### verif/icw_identify_words_tb.sv
`timescale 1ns/1ps
module icw_identify_words_tb;
	logic ref_clk;
	logic rst;
	logic pw_stored;
	logic pw_level_max;
	logic level1_power_cmds_disabled;
	icw_pkg::icw_id_req_t id_req;
	icw_pkg::icw_feat_t feat;
	icw_pkg::icw_sec_cmd_t sec_cmd;
	logic [15:0] id_data;
	logic id_valid;
	logic id_hit;
	logic feat_abort;
	logic sec_abort;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	icw_identify_words #(
		.ERASE_MIN(20),
		.ENH_ERASE_MIN(600),
		.ENH_ERASE_SUPPORTED(1'b1),
		.KEY_SCHEME_SUPPORTED(1'b1)
	) u_dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.id_req(id_req),
		.feat(feat),
		.sec_cmd(sec_cmd),
		.pw_stored(pw_stored),
		.pw_level_max(pw_level_max),
		.level1_power_cmds_disabled(level1_power_cmds_disabled),
		.id_data(id_data),
		.id_valid(id_valid),
		.id_hit(id_hit),
		.feat_abort(feat_abort),
		.sec_abort(sec_abort)
	);
	icw_host_model u_host (
		.ref_clk(ref_clk),
		.id_req(id_req),
		.feat(feat),
		.sec_cmd(sec_cmd),
		.id_data(id_data),
		.id_valid(id_valid),
		.id_hit(id_hit),
		.feat_abort(feat_abort),
		.sec_abort(sec_abort)
	);
	initial
	begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic end_of_test;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic eh);
		logic [15:0] d;
		logic v;
		logic h;
		u_host.read_word(a, d, v, h);
		check("valid_hit", {14'h0000, 1'b1, eh}, {14'h0000, v, h});
		check($sformatf("word %h", a), e, d);
	endtask
	task automatic ft(input logic [7:0] s, input logic [7:0] c, input logic ea);
		logic ab;
		u_host.set_feat(s, c, ab);
		check("feat_abort", {15'h0000, ea}, {15'h0000, ab});
	endtask
	task automatic sc(input icw_pkg::icw_sec_op_t op, input logic ok, input logic lm, input logic ea);
		logic ab;
		u_host.sec(op, ok, lm, ab);
		check("sec_abort", {15'h0000, ea}, {15'h0000, ab});
	endtask
	task automatic do_reset(input logic st, input logic lm);
		#1 rst = 1'b1;
		pw_stored = st;
		pw_level_max = lm;
		repeat (20) @(posedge ref_clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask
	task automatic t_static;
		rd(8'h55, 16'h4000, 1'b1);
		rd(8'h56, 16'h0004, 1'b1);
		rd(8'h58, 16'h003f, 1'b1);
		rd(8'h59, 16'h000a, 1'b1);
		rd(8'h5a, 16'h00ff, 1'b1);
		rd(8'h5b, 16'h0000, 1'b1);
		rd(8'h80, 16'h0021, 1'b1);
		rd(8'ha0, 16'h9064, 1'b1);
		level1_power_cmds_disabled = 1'b0;
		rd(8'ha0, 16'h8064, 1'b1);
		rd(8'ha2, 16'h0001, 1'b1);
		rd(8'ha3, 16'h0012, 1'b1);
		rd(8'ha4, 16'h001b, 1'b1);
		rd(8'h57, 16'h0000, 1'b0);
	endtask
	task automatic t_apm;
		ft(8'h05, 8'h80, 1'b0);
		rd(8'h56, 16'h000c, 1'b1);
		rd(8'h5b, 16'h0080, 1'b1);
		ft(8'h05, 8'h00, 1'b1);
		ft(8'h85, 8'h00, 1'b0);
		rd(8'h56, 16'h0004, 1'b1);
		rd(8'h5b, 16'h0000, 1'b1);
	endtask
	task automatic t_dma;
		for (int i = 0; i < 6; i++)
		begin
			ft(8'h03, 8'h40 + 8'(i), 1'b0);
			rd(8'h58, 16'h003f | (16'h0100 << i), 1'b1);
		end
		ft(8'h03, 8'h46, 1'b1);
		ft(8'h03, 8'h25, 1'b1);
		ft(8'h03, 8'h0f, 1'b1);
		ft(8'h03, 8'h10, 1'b1);
		ft(8'h02, 8'h00, 1'b0);
		ft(8'h03, 8'h24, 1'b0);
		rd(8'h58, 16'h003f, 1'b1);
		rd(8'ha3, 16'h0412, 1'b1);
		ft(8'h03, 8'h23, 1'b0);
		rd(8'ha3, 16'h0212, 1'b1);
		ft(8'h03, 8'h0e, 1'b0);
		ft(8'h03, 8'h41, 1'b0);
		rd(8'ha3, 16'h0092, 1'b1);
	endtask
	task automatic t_security;
		sc(icw_pkg::ICW_SOP_SET_PW, 1'b1, 1'b1, 1'b0);
		rd(8'h80, 16'h0123, 1'b1);
		repeat (5) sc(icw_pkg::ICW_SOP_UNLOCK, 1'b0, 1'b0, 1'b1);
		rd(8'h80, 16'h0133, 1'b1);
		sc(icw_pkg::ICW_SOP_UNLOCK, 1'b1, 1'b0, 1'b1);
		sc(icw_pkg::ICW_SOP_ERASE, 1'b1, 1'b0, 1'b1);
		sc(icw_pkg::ICW_SOP_FREEZE, 1'b1, 1'b0, 1'b0);
		rd(8'h80, 16'h013b, 1'b1);
		sc(icw_pkg::ICW_SOP_SET_PW, 1'b1, 1'b1, 1'b1);
		do_reset(1'b1, 1'b0);
		rd(8'h80, 16'h0027, 1'b1);
		sc(icw_pkg::ICW_SOP_FREEZE, 1'b1, 1'b0, 1'b1);
		sc(icw_pkg::ICW_SOP_UNLOCK, 1'b1, 1'b0, 1'b0);
		rd(8'h80, 16'h0023, 1'b1);
		sc(icw_pkg::ICW_SOP_DISABLE, 1'b0, 1'b0, 1'b1);
		sc(icw_pkg::ICW_SOP_DISABLE, 1'b1, 1'b0, 1'b0);
		rd(8'h80, 16'h0021, 1'b1);
		sc(icw_pkg::ICW_SOP_SET_PW, 1'b1, 1'b0, 1'b0);
		sc(icw_pkg::ICW_SOP_ERASE, 1'b1, 1'b0, 1'b0);
		rd(8'h80, 16'h0021, 1'b1);
		sc(icw_pkg::ICW_SOP_SET_PW, 1'b1, 1'b0, 1'b0);
		sc(icw_pkg::ICW_SOP_FREEZE, 1'b1, 1'b0, 1'b0);
		sc(icw_pkg::ICW_SOP_ERASE, 1'b1, 1'b0, 1'b1);
		rd(8'h80, 16'h002b, 1'b1);
		do_reset(1'b1, 1'b1);
		rd(8'h80, 16'h0127, 1'b1);
	endtask
	initial
	begin
		rst = 1'b1;
		pw_stored = 1'b0;
		pw_level_max = 1'b0;
		level1_power_cmds_disabled = 1'b1;
		do_reset(1'b0, 1'b0);
		t_static();
		t_apm();
		t_dma();
		t_security();
		end_of_test();
	end
endmodule
